// file: pkg/tcs_pkg.sv
package tcs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PERIOD_NS        = 10;                   // 100 MHz crystal clock
  localparam int SECOND_NS        = 1000000000;
  localparam int SECOND_CYCLES    = SECOND_NS / PERIOD_NS;
  localparam int PULSE_OUT_NS     = 1000000;              // Width of a driven sync pulse
  localparam int PULSE_OUT_CYCLES = PULSE_OUT_NS / PERIOD_NS;
  localparam logic [31:0] STEP_NS        = 32'h0000000a;  // Nanoseconds added per clock
  localparam logic [31:0] THRESH_DEFAULT = 32'h00000254;  // 596 ns health threshold

  // ****************************************************************
  // Source selector codes
  // ****************************************************************
  localparam logic [2:0] in_none_choice             = 3'h0;
  localparam logic [2:0] serial_pulse_input_choice  = 3'h1;
  localparam logic [2:0] host_input_choice          = 3'h2;  // Present, unused
  localparam logic [2:0] internal_input_choice      = 3'h3;
  localparam logic [2:0] auxiliary_input_choice     = 3'h4;  // Present, unused
  localparam logic [2:0] out_none_choice            = 3'h0;
  localparam logic [2:0] pulse_repeat_output_choice = 3'h1;
  localparam logic [2:0] loop_output_choice         = 3'h2;
  localparam logic [2:0] host_output_choice         = 3'h3;  // Present, unused
  localparam logic [2:0] master_output_choice       = 3'h4;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_THRESH      = 8'h04;
  localparam logic [7:0] OFF_HOST_SEC    = 8'h08;
  localparam logic [7:0] OFF_HOST_NSEC   = 8'h0c;
  localparam logic [7:0] OFF_TIME_SEC    = 8'h10;
  localparam logic [7:0] OFF_TIME_NSEC   = 8'h14;
  localparam logic [7:0] OFF_STATUS      = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT    = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h20;
  localparam logic [7:0] OFF_PULSE_TOTAL = 8'h24;
  localparam logic [7:0] OFF_PULSE_BAD   = 8'h28;
  localparam logic [7:0] OFF_MISSED      = 8'h2c;
  localparam logic [7:0] OFF_LONGEST     = 8'h30;
  localparam logic [7:0] OFF_PHASE_ERR   = 8'h34;
  localparam logic [7:0] OFF_FREQ_ERR    = 8'h38;
  localparam logic [7:0] OFF_WORST_PHASE = 8'h3c;
  localparam logic [7:0] OFF_WORST_FREQ  = 8'h40;
  localparam logic [7:0] OFF_RESYNCS     = 8'h44;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_IN_LSB    = 0;   // [2:0] input selector
  localparam int CTRL_OUT_LSB   = 4;   // [6:4] output selector
  localparam int CTRL_SET_BIT   = 8;   // Write 1: load time from host
  localparam int CTRL_FULL_BIT  = 9;   // Write 1: full clock reset
  localparam int CTRL_CLEAR_BIT = 10;  // Write 1: clear statistics
  localparam int STAT_SYNC_BIT  = 0;
  localparam int STAT_LOAD_BIT  = 1;
  localparam int IRQ_W          = 5;
  localparam int IRQ_PULSE      = 0;
  localparam int IRQ_BAD        = 1;
  localparam int IRQ_MISSED     = 2;
  localparam int IRQ_LOST       = 3;
  localparam int IRQ_RESYNC     = 4;

endpackage

// file: pkg/tcs_pulse_if.sv
`timescale 1ns/1ns
// Events from the reference pulse monitor to the clock core
interface tcs_pulse_if;
  logic level;   // Synchronised pulse pin level
  logic good;    // One-cycle: well-timed pulse edge
  logic bad;     // One-cycle: pulse edge far too early
  logic missed;  // One-cycle: expected pulse did not arrive

  modport mon
  (
    output level,
    output good,
    output bad,
    output missed
  );
  modport core
  (
    input level,
    input good,
    input bad,
    input missed
  );
endinterface

// file: src/tcs_pulse_mon.sv
`timescale 1ns/1ns
module tcs_pulse_mon #(
  parameter int SEC_CYCLES = tcs_pkg::SECOND_CYCLES
) (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  input  wire logic  pps_in,
  tcs_pulse_if.mon   ev
);

  localparam logic [31:0] HALF_SEC = 32'(SEC_CYCLES / 2);
  localparam logic [31:0] MISS_AT  = 32'(SEC_CYCLES + SEC_CYCLES / 2);

  logic        sync_a;
  logic        sync_b;
  logic        prev;
  logic        armed;
  logic [31:0] gap;
  logic        rise;

  // Pin crosses in through two flops; only the second is read
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end
    else
    begin
      sync_a <= pps_in;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign rise     = sync_b & ~prev;
  assign ev.level = sync_b;

  // Interval check; a miss restarts the gap at half a second so runs of misses count once per second
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap       <= 32'h00000000;
      armed     <= 1'b0;
      ev.good   <= 1'b0;
      ev.bad    <= 1'b0;
      ev.missed <= 1'b0;
    end
    else
    begin
      ev.good   <= 1'b0;
      ev.bad    <= 1'b0;
      ev.missed <= 1'b0;
      if (rise)
      begin
        gap <= 32'h00000000;
        if (armed && gap < HALF_SEC)
          ev.bad <= 1'b1;
        else
        begin
          ev.good <= 1'b1;
          armed   <= 1'b1;
        end
      end
      else if (armed && gap == MISS_AT)
      begin
        ev.missed <= 1'b1;
        gap       <= HALF_SEC;
      end
      else
        gap <= gap + 32'h00000001;
    end
  end

endmodule

// file: src/tcs_top.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module tcs_top #(
  parameter int SEC_CYCLES   = tcs_pkg::SECOND_CYCLES,
  parameter int PULSE_CYCLES = tcs_pkg::PULSE_OUT_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        pps_in,
  output logic             sync_out,
  output logic             sync_out_oe,
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [31:0] NS_LIMIT = 32'(SEC_CYCLES * int'(tcs_pkg::STEP_NS));
  localparam logic [31:0] NS_HALF  = 32'(SEC_CYCLES * int'(tcs_pkg::STEP_NS) / 2);
  localparam logic [31:0] ONE      = 32'h00000001;
  localparam logic [31:0] ZERO     = 32'h00000000;

  tcs_pulse_if pev ();

  logic [2:0]         in_sel;
  logic [2:0]         out_sel;
  logic [31:0]        thresh;
  logic [31:0]        host_sec;
  logic [31:0]        host_ns;
  logic [31:0]        sec;
  logic [31:0]        ns;
  logic               loaded;
  logic               synced;
  logic signed [31:0] slew;
  logic signed [31:0] phase_err;
  logic signed [31:0] freq_err;
  logic signed [31:0] last_phase;
  logic [31:0]        worst_phase;
  logic [31:0]        worst_freq;
  logic [31:0]        cnt_total;
  logic [31:0]        cnt_bad;
  logic [31:0]        cnt_missed;
  logic [31:0]        miss_run;
  logic [31:0]        cnt_longest;
  logic [31:0]        cnt_resync;
  logic [tcs_pkg::IRQ_W-1:0] irq_stat;
  logic [tcs_pkg::IRQ_W-1:0] irq_mask;
  logic [tcs_pkg::IRQ_W-1:0] irq_ev;
  logic [31:0]        pulse_cnt;
  logic               int_pulse;

  logic               wr_en;
  logic               host_mark;
  logic               do_set;
  logic               do_full;
  logic               do_clear;
  logic               ref_evt;
  logic               sec_ok;
  logic               do_step;
  logic signed [31:0] phase;
  logic [31:0]        phase_abs;
  logic [31:0]        next_ns;
  logic               wrap;
  logic               next_synced;
  logic               trig;
  logic               unmapped;
  logic [31:0]        rd_val;

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // ****************************************************************
  // Reference pulse monitor
  // ****************************************************************
  tcs_pulse_mon #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_mon (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pps_in  (pps_in),
    .ev      (pev.mon)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // No wait state; read data leaves a flop set in the setup cycle; writes land on the completing edge
  assign wr_en     = psel & penable & pready & pwrite;
  assign host_mark = wr_en && paddr == tcs_pkg::OFF_HOST_NSEC;
  assign do_set    = wr_en && paddr == tcs_pkg::OFF_CTRL && pwdata[tcs_pkg::CTRL_SET_BIT];
  assign do_full   = wr_en && paddr == tcs_pkg::OFF_CTRL && pwdata[tcs_pkg::CTRL_FULL_BIT];
  assign do_clear  = wr_en && paddr == tcs_pkg::OFF_CTRL && pwdata[tcs_pkg::CTRL_CLEAR_BIT];

  // Read mux over every mapped word
  always_comb
  begin
    unmapped = 1'b0;
    unique case (paddr)
      tcs_pkg::OFF_CTRL:        rd_val = {25'h0000000, out_sel, 1'b0, in_sel};
      tcs_pkg::OFF_THRESH:      rd_val = thresh;
      tcs_pkg::OFF_HOST_SEC:    rd_val = host_sec;
      tcs_pkg::OFF_HOST_NSEC:   rd_val = host_ns;
      tcs_pkg::OFF_TIME_SEC:    rd_val = sec;
      tcs_pkg::OFF_TIME_NSEC:   rd_val = ns;
      tcs_pkg::OFF_STATUS:      rd_val = {30'h00000000, loaded, synced};
      tcs_pkg::OFF_IRQ_STAT:    rd_val = 32'(irq_stat);
      tcs_pkg::OFF_IRQ_MASK:    rd_val = 32'(irq_mask);
      tcs_pkg::OFF_PULSE_TOTAL: rd_val = cnt_total;
      tcs_pkg::OFF_PULSE_BAD:   rd_val = cnt_bad;
      tcs_pkg::OFF_MISSED:      rd_val = cnt_missed;
      tcs_pkg::OFF_LONGEST:     rd_val = cnt_longest;
      tcs_pkg::OFF_PHASE_ERR:   rd_val = phase_err;
      tcs_pkg::OFF_FREQ_ERR:    rd_val = freq_err;
      tcs_pkg::OFF_WORST_PHASE: rd_val = worst_phase;
      tcs_pkg::OFF_WORST_FREQ:  rd_val = worst_freq;
      tcs_pkg::OFF_RESYNCS:     rd_val = cnt_resync;
      default:
      begin
        rd_val   = ZERO;
        unmapped = 1'b1;
      end
    endcase
  end

  // Answer in the first access cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      prdata  <= ZERO;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & unmapped;
      if (psel && !penable && !pwrite)
        prdata <= rd_val;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // A reload of the logic resets these; software must rewrite them
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_sel   <= tcs_pkg::serial_pulse_input_choice;
      out_sel  <= tcs_pkg::out_none_choice;
      thresh   <= tcs_pkg::THRESH_DEFAULT;
      irq_mask <= '0;
      host_sec <= ZERO;
      host_ns  <= ZERO;
    end
    else
    begin
      if (do_full)
      begin
        in_sel  <= tcs_pkg::serial_pulse_input_choice;
        out_sel <= tcs_pkg::out_none_choice;
      end
      else if (wr_en && paddr == tcs_pkg::OFF_CTRL)
      begin
        in_sel  <= pwdata[tcs_pkg::CTRL_IN_LSB +: 3];
        out_sel <= pwdata[tcs_pkg::CTRL_OUT_LSB +: 3];
      end
      if (wr_en && paddr == tcs_pkg::OFF_THRESH)
        thresh <= pwdata;
      if (wr_en && paddr == tcs_pkg::OFF_IRQ_MASK)
        irq_mask <= pwdata[tcs_pkg::IRQ_W-1:0];
      if (wr_en && paddr == tcs_pkg::OFF_HOST_SEC)
        host_sec <= pwdata;
      if (host_mark)
        host_ns <= pwdata;
    end
  end

  // ****************************************************************
  // Reference selection and phase measurement
  // ****************************************************************
  // Host and aux choices carry no reference: the clock free-runs
  always_comb
  begin
    ref_evt = 1'b0;
    sec_ok  = 1'b1;
    phase   = '0;
    unique case (in_sel)
      tcs_pkg::serial_pulse_input_choice:
      begin
        ref_evt = pev.good & loaded;
        phase   = (ns < NS_HALF) ? $signed(ns) : $signed(ns - NS_LIMIT);
      end
      tcs_pkg::internal_input_choice:
      begin
        ref_evt = host_mark & loaded;
        sec_ok  = (host_sec == sec);
        phase   = $signed(ns - pwdata);
      end
      default:
      begin
        ref_evt = 1'b0;
      end
    endcase
  end

  assign phase_abs = mag(phase);
  assign do_step   = ref_evt & (~sec_ok | (phase_abs > thresh));

  // ****************************************************************
  // Local time
  // ****************************************************************
  // Slew trims one nanosecond per tick so small corrections never jump
  always_comb
  begin
    if (slew > 0)
      next_ns = ns + tcs_pkg::STEP_NS + ONE;
    else if (slew < 0)
      next_ns = ns + tcs_pkg::STEP_NS - ONE;
    else
      next_ns = ns + tcs_pkg::STEP_NS;
  end

  assign wrap = loaded & (next_ns >= NS_LIMIT);

  // Load beats step beats free running
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sec    <= ZERO;
      ns     <= ZERO;
      loaded <= 1'b0;
      slew   <= '0;
    end
    else if (do_set || do_full)
    begin
      sec    <= host_sec;
      ns     <= host_ns;
      loaded <= 1'b1;
      slew   <= '0;
    end
    else if (do_step && in_sel == tcs_pkg::internal_input_choice)
    begin
      sec  <= host_sec;
      ns   <= pwdata;
      slew <= '0;
    end
    else if (do_step)
    begin
      ns   <= ZERO;
      sec  <= phase[31] ? sec + ONE : sec;
      slew <= '0;
    end
    else if (loaded)
    begin
      ns  <= wrap ? next_ns - NS_LIMIT : next_ns;
      sec <= wrap ? sec + ONE : sec;
      if (ref_evt)
        slew <= -phase;
      else if (slew > 0)
        slew <= slew - 32'sd1;
      else if (slew < 0)
        slew <= slew + 32'sd1;
    end
  end

  // ****************************************************************
  // Health and statistics
  // ****************************************************************
  always_comb
  begin
    next_synced = synced;
    if (do_step || (pev.missed && in_sel == tcs_pkg::serial_pulse_input_choice))
      next_synced = 1'b0;
    else if (ref_evt)
      next_synced = 1'b1;
    if (in_sel != tcs_pkg::serial_pulse_input_choice && in_sel != tcs_pkg::internal_input_choice)
      next_synced = 1'b0;
  end

  // Error tracking; frequency error is the phase drift per second, so ns/s equals ppb
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      synced      <= 1'b0;
      phase_err   <= '0;
      freq_err    <= '0;
      last_phase  <= '0;
      worst_phase <= ZERO;
      worst_freq  <= ZERO;
    end
    else
    begin
      synced <= next_synced;
      if (do_clear)
      begin
        worst_phase <= ZERO;
        worst_freq  <= ZERO;
      end
      else if (ref_evt)
      begin
        phase_err  <= phase;
        freq_err   <= phase - last_phase;
        last_phase <= phase;
        if (phase_abs > worst_phase)
          worst_phase <= phase_abs;
        if (mag(phase - last_phase) > worst_freq)
          worst_freq <= mag(phase - last_phase);
      end
    end
  end

  // Pulse and resync counters
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_total   <= ZERO;
      cnt_bad     <= ZERO;
      cnt_missed  <= ZERO;
      miss_run    <= ZERO;
      cnt_longest <= ZERO;
      cnt_resync  <= ZERO;
    end
    else if (do_clear)
    begin
      cnt_total   <= ZERO;
      cnt_bad     <= ZERO;
      cnt_missed  <= ZERO;
      miss_run    <= ZERO;
      cnt_longest <= ZERO;
      cnt_resync  <= ZERO;
    end
    else
    begin
      if (pev.good)
      begin
        cnt_total <= cnt_total + ONE;
        miss_run  <= ZERO;
      end
      if (pev.bad)
        cnt_bad <= cnt_bad + ONE;
      if (pev.missed)
      begin
        cnt_missed <= cnt_missed + ONE;
        miss_run   <= miss_run + ONE;
        if (miss_run + ONE > cnt_longest)
          cnt_longest <= miss_run + ONE;
      end
      if (do_step)
        cnt_resync <= cnt_resync + ONE;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_ev[tcs_pkg::IRQ_PULSE]  = pev.good;
  assign irq_ev[tcs_pkg::IRQ_BAD]    = pev.bad;
  assign irq_ev[tcs_pkg::IRQ_MISSED] = pev.missed;
  assign irq_ev[tcs_pkg::IRQ_LOST]   = synced & ~next_synced;
  assign irq_ev[tcs_pkg::IRQ_RESYNC] = do_step;

  // Sticky, write one to clear; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == tcs_pkg::OFF_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[tcs_pkg::IRQ_W-1:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // Sync output
  // ****************************************************************
  // Master pulses mark each local second; loop of host time marks each host nanoseconds write once time is loaded
  assign trig = (out_sel == tcs_pkg::master_output_choice && wrap) ||
                (out_sel == tcs_pkg::loop_output_choice &&
                 in_sel == tcs_pkg::internal_input_choice && ref_evt);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulse_cnt <= ZERO;
      int_pulse <= 1'b0;
    end
    else
    begin
      if (trig)
        pulse_cnt <= 32'(PULSE_CYCLES);
      else if (pulse_cnt != ZERO)
        pulse_cnt <= pulse_cnt - ONE;
      int_pulse <= trig || (pulse_cnt > ONE);
    end
  end

  // Output pin and its enable; host output choice drives nothing
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_out    <= 1'b0;
      sync_out_oe <= 1'b0;
    end
    else
    begin
      sync_out_oe <= (out_sel == tcs_pkg::pulse_repeat_output_choice) ||
                     (out_sel == tcs_pkg::loop_output_choice) ||
                     (out_sel == tcs_pkg::master_output_choice);
      unique case (out_sel)
        tcs_pkg::pulse_repeat_output_choice: sync_out <= pev.level;
        tcs_pkg::loop_output_choice:
          sync_out <= (in_sel == tcs_pkg::serial_pulse_input_choice) ? pev.level : int_pulse;
        tcs_pkg::master_output_choice:       sync_out <= int_pulse;
        default:                             sync_out <= 1'b0;
      endcase
    end
  end

endmodule

// file: testbench/tcs_pps_src.sv
`timescale 1ns/1ns
// ****
// Pulse-per-second reference source
// ****
module tcs_pps_src (
  input  wire logic        sys_clk,
  input  wire logic        run,
  input  wire logic [15:0] gap,
  output logic             pps_in
);
  logic [15:0] cnt = 16'h0000;

  // Period is gap+1 cycles; a short gap makes a pulse come too early
  always @(posedge sys_clk)
  begin
    cnt    <= (!run || cnt == gap) ? 16'h0000 : cnt + 16'h0001;
    pps_in <= run && cnt < 16'h0014;
  end
endmodule

// file: testbench/tcs_checker.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module tcs_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        pps_in,
  input wire logic        sync_out,
  input wire logic        sync_out_oe,
  input wire logic        irq
);
  logic ctrl_w;
  logic wr_d;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Control write seen now or one cycle ago may still move the pin enable
  assign ctrl_w = psel && penable && pwrite && paddr == 8'h00;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      wr_d <= 1'b0;
    else
      wr_d <= ctrl_w;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence

  chk_ready_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (pready && paddr > 8'h44 |-> pslverr)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (pready && paddr <= 8'h44 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_out_off: assert property (s_ctrl_wr ##0 (pwdata[9] || pwdata[6:4] == 3'h0) |-> ##[1:2] !sync_out_oe)
    else $error("output still driven");
  chk_out_on: assert property (s_ctrl_wr ##0 (!pwdata[9] && pwdata[6:4] inside {3'h1, 3'h2, 3'h4})
    |-> ##[1:2] sync_out_oe)
    else $error("output not driven");
  chk_oe_hold: assert property (!ctrl_w && !wr_d |=> $stable(sync_out_oe))
    else $error("pin enable moved without a write");
  chk_irq_masked: assert property (pready && pwrite && paddr == 8'h20 && pwdata == 32'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
  chk_rst_quiet: assert property ($fell(sys_rst) |-> !irq && !sync_out_oe && !pready)
    else $error("outputs active after reset");
endmodule

bind tcs_top tcs_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .pps_in(pps_in), .sync_out(sync_out), .sync_out_oe(sync_out_oe), .irq(irq));

// file: testbench/testbench.sv
`timescale 1ns/1ns
// ****
// Self-checking bench
// ****
module testbench;
  logic        sys_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic        run         = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] seed        = 32'ha0198864;
  logic [15:0] gap         = 16'h03e7;
  logic [31:0] prdata;
  logic        pready, pslverr, pps_in, sync_out, sync_out_oe, irq;
  logic [64:0] q[$];
  logic [64:0] e;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          n;

  always #5 sys_clk = ~sys_clk;

  tcs_top #(.SEC_CYCLES(1000), .PULSE_CYCLES(10)) i_tcs_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pps_in(pps_in), .sync_out(sync_out), .sync_out_oe(sync_out_oe),
    .irq(irq));
  tcs_pps_src i_tcs_pps_src (.sys_clk(sys_clk), .run(run), .gap(gap), .pps_in(pps_in));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] x);
    n_tests++;
    if (s !== x)
    begin
      $display("wrong value %s expected %h seen %h", nm, x, s);
      miscompares++;
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One transfer; a read notes {refusal, mask, data} for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int k;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    if (!w)
      q.push_back({a > 8'h44, m, d});
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1)
      miscompares++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read data is judged at the edge where the access completes
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite && q.size() > 0)
    begin
      e = q.pop_front();
      check("read data", {pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end

  // Hang guard, far beyond the planned run length
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(0, 8'h00, 32'h1, 32'h77);
    apb(0, 8'h04, 32'h254, 32'hffffffff);
    apb(0, 8'h18, 32'h0, 32'h2);
    apb(0, 8'h48, 32'h0, 32'hffffffff);
    seed = xs(seed);
    apb(1, 8'h04, seed, 32'h0);
    apb(0, 8'h04, seed, 32'hffffffff);
    seed = xs(seed);
    apb(1, 8'h08, seed, 32'h0);
    apb(1, 8'h0c, 32'h0, 32'h0);
    apb(1, 8'h00, 32'h100, 32'h0);
    apb(0, 8'h10, seed, 32'hffffffff);
    apb(0, 8'h18, 32'h2, 32'h2);
    repeat (1000) @(posedge sys_clk);
    apb(0, 8'h10, seed + 32'h1, 32'hffffffff);
    // Host time step while disciplined to host time
    apb(1, 8'h00, 32'h3, 32'h0);
    seed = xs(seed);
    apb(1, 8'h08, seed, 32'h0);
    apb(1, 8'h0c, 32'h0, 32'h0);
    apb(0, 8'h10, seed, 32'hffffffff);
    apb(1, 8'h00, 32'h243, 32'h0);
    apb(0, 8'h00, 32'h1, 32'h77);
    // Master output pulse at each local second
    apb(1, 8'h00, 32'h40, 32'h0);
    n = 0;
    while (sync_out !== 1'b1 && n < 1100)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("master oe", 33'(sync_out_oe), 33'h1);
    n = 0;
    while (sync_out === 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("master width", 33'(n >= 10 && n < 100), 33'h1);
    // Reference pulses repeated out, counted and flagged
    apb(1, 8'h00, 32'h411, 32'h0);
    apb(1, 8'h04, 32'h254, 32'h0);
    apb(1, 8'h20, 32'h1, 32'h0);
    run <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("repeat pin", 33'({sync_out, sync_out_oe}), 33'h3);
    check("irq raised", 33'(irq), 33'h1);
    apb(1, 8'h20, 32'h0, 32'h0);
    apb(1, 8'h20, 32'h1, 32'h0);
    apb(1, 8'h1c, 32'h1f, 32'h0);
    apb(0, 8'h1c, 32'h0, 32'h1f);
    check("irq cleared", 33'(irq), 33'h0);
    repeat (2000) @(posedge sys_clk);
    apb(0, 8'h18, 32'h3, 32'h3);
    gap <= 16'h00c8;
    repeat (200) @(posedge sys_clk);
    run <= 1'b0;
    repeat (1700) @(posedge sys_clk);
    apb(0, 8'h24, 32'h3, 32'hffffffff);
    apb(0, 8'h28, 32'h1, 32'hffffffff);
    apb(0, 8'h2c, 32'h1, 32'hffffffff);
    // Loop of host-time input: each host mark sends a pulse out
    apb(1, 8'h00, 32'h23, 32'h0);
    apb(1, 8'h0c, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    check("loop pin", 33'({sync_out, sync_out_oe}), 33'h3);
    close_out;
  end
endmodule
